// File: logic/cfg_frame_pkg.sv
// Constants and carrier types for the frame address sequencer.
// Assumes one clock and one reset shared by the packet processor and frame storage.
package cfg_frame_pkg;
  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int FRAME_BITS = 1312;
  localparam int HALF_BITS = 640;
  localparam int HCLK_BITS = 32;
  localparam int WORD_BITS = 32;
  localparam logic [5:0] LAST_WORD = 6'h28;
  localparam int HCLK_LSB = 640;
  localparam int HCLK_USED = 16;
  localparam int SPC_GTS_BIT = 14;
  localparam int SPC_CAPRES_BIT = 13;
  localparam int SPC_HOLD_BIT = 12;
  // ----------------------------------------
  // Block types and column kinds
  // ----------------------------------------
  localparam logic [2:0] BT_CONFIG = 3'h0;
  localparam logic [2:0] BT_BRAM_CONTENT = 3'h1;
  localparam logic [2:0] BT_SPECIAL = 3'h2;
  localparam logic [2:0] BT_BRAM_NONCFG = 3'h3;
  localparam logic [2:0] COL_LOGIC = 3'h0;
  localparam logic [2:0] COL_ARITH = 3'h1;
  localparam logic [2:0] COL_BRAM = 3'h2;
  localparam logic [2:0] COL_IO = 3'h3;
  localparam logic [2:0] COL_CLOCK = 3'h4;
  localparam logic [7:0] FR_LOGIC = 8'h24;
  localparam logic [7:0] FR_ARITH = 8'h1c;
  localparam logic [7:0] FR_BRAM = 8'h1e;
  localparam logic [7:0] FR_IO = 8'h36;
  localparam logic [7:0] FR_CLOCK = 8'h04;
  localparam logic [7:0] FR_CONTENT = 8'h80;
  localparam logic [7:0] FR_SPECIAL = 8'h01;
  localparam logic [7:0] FR_NONCFG = 8'h01;
  localparam logic [6:0] MINOR_IC_LAST = 7'h19;
  localparam logic [6:0] MINOR_IF_LAST = 7'h1b;
  localparam logic [4:0] ROWS_MAX = 5'h0a;
  localparam logic [1:0] ROLE_INTERCONNECT = 2'h0;
  localparam logic [1:0] ROLE_INTERFACE = 2'h1;
  localparam logic [1:0] ROLE_SPECIFIC = 2'h2;
  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_FAR = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_GATES = 12'h00c;
  localparam int STS_BADTYPE_BIT = 16;
  localparam logic [7:0] RST_NCOLS = 8'h08;
  localparam logic [7:0] RST_NBRAM = 8'h03;
  localparam logic [3:0] RST_NROWS = 4'ha;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] unused;
    logic [2:0] block_type;
    logic bottom;
    logic [4:0] row;
    logic [7:0] major;
    logic [6:0] minor;
  } far_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
  typedef struct packed {
    far_type addr;
    logic [1:0] role;
    logic [FRAME_BITS-1:0] data;
  } frame_out_type;
  typedef struct packed {
    far_type frame_address_register;
    logic [FRAME_BITS-1:0] shreg;
    logic [5:0] wcnt;
    logic fvalid;
    frame_out_type fout;
    logic [7:0] ncols;
    logic [7:0] nbram;
    logic [3:0] nrows;
    logic enable;
    logic bad_type;
    logic [15:0] nframes;
    logic [2:0] gates;
    logic [31:0] prdata;
    logic pslverr;
  } state_type;
endpackage

// File: logic/config_frame_addressing.sv
// Frame address decoder and sequencer: collects bitstream words into frames and steps the frame address.
// Assumes the packet processor and frame storage share pclk; column_kind is looked up by storage
// for the major address currently held in the frame address register.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module config_frame_addressing (
  input wire logic pclk,
  input wire logic presetn,
  input wire cfg_frame_pkg::apb_req_type apb_in,
  output cfg_frame_pkg::apb_rsp_type apb_out,
  input wire logic far_load,
  input wire logic [31:0] far_value,
  input wire logic word_valid,
  input wire logic [31:0] word_data,
  output logic word_ready,
  input wire logic [2:0] column_kind,
  output logic frame_valid,
  output cfg_frame_pkg::frame_out_type frame_out,
  output logic gts_gate,
  output logic capture_restore_gate,
  output logic hold_gwe_gate
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Frame count of a column for a block type; unused codes give zero.
  function automatic logic [7:0] frames_in_col(logic [2:0] bt, logic [2:0] kind);
    logic [7:0] f;
    f = 8'h00;
    case (bt)
      cfg_frame_pkg::BT_CONFIG: begin
        case (kind)
          cfg_frame_pkg::COL_LOGIC: f = cfg_frame_pkg::FR_LOGIC;
          cfg_frame_pkg::COL_ARITH: f = cfg_frame_pkg::FR_ARITH;
          cfg_frame_pkg::COL_BRAM: f = cfg_frame_pkg::FR_BRAM;
          cfg_frame_pkg::COL_IO: f = cfg_frame_pkg::FR_IO;
          cfg_frame_pkg::COL_CLOCK: f = cfg_frame_pkg::FR_CLOCK;
          default: f = 8'h00;
        endcase
      end
      cfg_frame_pkg::BT_BRAM_CONTENT: f = cfg_frame_pkg::FR_CONTENT;
      cfg_frame_pkg::BT_SPECIAL: f = cfg_frame_pkg::FR_SPECIAL;
      cfg_frame_pkg::BT_BRAM_NONCFG: f = cfg_frame_pkg::FR_NONCFG;
      default: f = 8'h00;
    endcase
    return f;
  endfunction

  // Role of a minor frame within its column.
  function automatic logic [1:0] role_of(cfg_frame_pkg::far_type a, logic [2:0] kind);
    logic [1:0] r;
    r = cfg_frame_pkg::ROLE_SPECIFIC;
    if (a.block_type == cfg_frame_pkg::BT_CONFIG && kind != cfg_frame_pkg::COL_CLOCK) begin
      if (a.minor <= cfg_frame_pkg::MINOR_IC_LAST) begin
        r = cfg_frame_pkg::ROLE_INTERCONNECT;
      end else if (a.minor <= cfg_frame_pkg::MINOR_IF_LAST && kind != cfg_frame_pkg::COL_LOGIC) begin
        r = cfg_frame_pkg::ROLE_INTERFACE;
      end
    end
    return r;
  endfunction

  // Step minor, then major, then row; after the last top row the bottom half starts at row 0.
  function automatic cfg_frame_pkg::far_type advance(cfg_frame_pkg::far_type a, logic [7:0] frames,
                                                     logic [7:0] ncols, logic [3:0] nrows);
    cfg_frame_pkg::far_type r;
    r = a;
    if (({1'b0, a.minor} + 8'h01) < frames) begin
      r.minor = a.minor + 7'h01;
    end else begin
      r.minor = 7'h00;
      if (({1'b0, a.major} + 9'h001) < {1'b0, ncols}) begin
        r.major = a.major + 8'h01;
      end else begin
        r.major = 8'h00;
        if (({1'b0, a.row} + 6'h01) < {2'h0, nrows}) begin
          r.row = a.row + 5'h01;
        end else begin
          r.row = 5'h00;
          r.bottom = ~a.bottom;
        end
      end
    end
    return r;
  endfunction

  // Clear unused HCLK bits; a special frame keeps only its low HCLK bits.
  function automatic logic [cfg_frame_pkg::FRAME_BITS-1:0] mask_frame(logic [cfg_frame_pkg::FRAME_BITS-1:0] d,
                                                                     logic [2:0] bt);
    logic [cfg_frame_pkg::FRAME_BITS-1:0] m;
    m = d;
    m[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::HCLK_BITS-1:cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::HCLK_USED] = '0;
    if (bt == cfg_frame_pkg::BT_SPECIAL) begin
      m = '0;
      m[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::SPC_GTS_BIT:cfg_frame_pkg::HCLK_LSB] =
        d[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::SPC_GTS_BIT:cfg_frame_pkg::HCLK_LSB];
    end
    return m;
  endfunction

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  cfg_frame_pkg::state_type st_r;
  cfg_frame_pkg::state_type st_nxt;
  logic accept;
  logic last_word;
  logic [7:0] frames_cur;
  logic [7:0] ncols_seq;
  logic addr_ok;
  logic [cfg_frame_pkg::FRAME_BITS-1:0] full_frame;
  logic [2:0] spc_bits;

  // The block RAM contents type walks its own major sequence over block RAM columns only.
  assign accept = word_valid && word_ready && !far_load;
  assign last_word = st_r.wcnt == cfg_frame_pkg::LAST_WORD;
  assign frames_cur = frames_in_col(st_r.frame_address_register.block_type, column_kind);
  assign ncols_seq = (st_r.frame_address_register.block_type == cfg_frame_pkg::BT_BRAM_CONTENT) ? st_r.nbram : st_r.ncols;
  assign addr_ok = frames_cur != 8'h00 && st_r.frame_address_register.row < cfg_frame_pkg::ROWS_MAX &&
                   {1'b0, st_r.frame_address_register.minor} < frames_cur && st_r.frame_address_register.major < ncols_seq;
  // First word lands in the top bits; word 21 is the HCLK word, whatever the row.
  assign full_frame = {st_r.shreg[cfg_frame_pkg::FRAME_BITS-cfg_frame_pkg::WORD_BITS-1:0], word_data};
  assign spc_bits = {full_frame[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::SPC_GTS_BIT] && column_kind == cfg_frame_pkg::COL_IO,
                     full_frame[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::SPC_CAPRES_BIT],
                     full_frame[cfg_frame_pkg::HCLK_LSB+cfg_frame_pkg::SPC_HOLD_BIT]};

  // Next-state logic: register bus, address load and word collection.
  always_comb begin
    st_nxt = st_r;
    st_nxt.fvalid = 1'b0;
    // Read data is prepared in the setup cycle so it comes from a flip-flop.
    if (apb_in.psel && !apb_in.penable) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
      if (apb_in.paddr == cfg_frame_pkg::ADDR_CONFIG) begin
        st_nxt.prdata = {7'h00, st_r.enable, 4'h0, st_r.nrows, st_r.nbram, st_r.ncols};
      end else if (apb_in.paddr == cfg_frame_pkg::ADDR_FAR) begin
        st_nxt.prdata = st_r.frame_address_register;
      end else if (apb_in.paddr == cfg_frame_pkg::ADDR_STATUS) begin
        st_nxt.prdata = {2'h0, st_r.wcnt, 7'h00, st_r.bad_type, st_r.nframes};
      end else if (apb_in.paddr == cfg_frame_pkg::ADDR_GATES) begin
        st_nxt.prdata = {29'h0000_0000, st_r.gates};
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    if (apb_in.psel && apb_in.penable && apb_in.pwrite) begin
      if (apb_in.paddr == cfg_frame_pkg::ADDR_CONFIG) begin
        st_nxt.ncols = apb_in.pwdata[7:0];
        st_nxt.nbram = apb_in.pwdata[15:8];
        st_nxt.nrows = apb_in.pwdata[19:16];
        st_nxt.enable = apb_in.pwdata[24];
      end else if (apb_in.paddr == cfg_frame_pkg::ADDR_STATUS) begin
        if (apb_in.pwdata[cfg_frame_pkg::STS_BADTYPE_BIT]) begin
          st_nxt.bad_type = 1'b0;
        end
      end
    end
    // A new address discards any partial frame, so only whole frames are ever written.
    if (far_load) begin
      st_nxt.frame_address_register = far_value;
      st_nxt.wcnt = 6'h00;
    end else if (accept) begin
      st_nxt.shreg = full_frame;
      st_nxt.wcnt = st_r.wcnt + 6'h01;
      if (last_word) begin
        st_nxt.wcnt = 6'h00;
        st_nxt.nframes = st_r.nframes + 16'h0001;
        if (addr_ok) begin
          st_nxt.fvalid = 1'b1;
          st_nxt.fout.addr = st_r.frame_address_register;
          st_nxt.fout.role = role_of(st_r.frame_address_register, column_kind);
          st_nxt.fout.data = mask_frame(full_frame, st_r.frame_address_register.block_type);
          if (st_r.frame_address_register.block_type == cfg_frame_pkg::BT_SPECIAL) begin
            st_nxt.gates = spc_bits;
          end
          st_nxt.frame_address_register = advance(st_r.frame_address_register, frames_cur, ncols_seq, st_r.nrows);
        end else begin
          // Set wins over a clear in the same cycle because it is applied last.
          st_nxt.bad_type = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ncols <= cfg_frame_pkg::RST_NCOLS;
      st_r.nbram <= cfg_frame_pkg::RST_NBRAM;
      st_r.nrows <= cfg_frame_pkg::RST_NROWS;
      st_r.enable <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero-wait slave: every access phase ends in its first cycle.
  assign apb_out.pready = 1'b1;
  assign apb_out.prdata = st_r.prdata;
  assign apb_out.pslverr = st_r.pslverr;
  assign word_ready = st_r.enable;
  assign frame_valid = st_r.fvalid;
  assign frame_out = st_r.fout;
  assign gts_gate = st_r.gates[2];
  assign capture_restore_gate = st_r.gates[1];
  assign hold_gwe_gate = st_r.gates[0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_frame_done;
    accept && last_word && addr_ok;
  endsequence
  sequence s_top_end;
    s_frame_done ##0 (!st_r.frame_address_register.bottom && {1'b0, st_r.frame_address_register.minor} + 8'h01 == frames_cur &&
      {1'b0, st_r.frame_address_register.major} + 9'h001 == {1'b0, ncols_seq} && {1'b0, st_r.frame_address_register.row} + 6'h01 == {2'h0, st_r.nrows});
  endsequence
  sequence s_bram_col_end;
    s_frame_done ##0 (st_r.frame_address_register.block_type == cfg_frame_pkg::BT_BRAM_CONTENT && st_r.frame_address_register.minor == 7'h7f &&
      {1'b0, st_r.frame_address_register.major} + 9'h001 < {1'b0, ncols_seq});
  endsequence

  property p_frame_cause;
    frame_valid |-> $past(accept) && $past(st_r.wcnt) == 6'h28;
  endproperty
  a_frame_cause: assert property (p_frame_cause) else $error("frame without 41st word");
  property p_wcnt_range;
    st_r.wcnt <= 6'h28;
  endproperty
  a_wcnt_range: assert property (p_wcnt_range) else $error("word count past frame");
  property p_load;
    far_load |=> st_r.frame_address_register == $past(far_value) && st_r.wcnt == 6'h00;
  endproperty
  a_load: assert property (p_load) else $error("address load lost");
  property p_hclk_upper;
    frame_valid |-> frame_out.data[671:656] == 16'h0000;
  endproperty
  a_hclk_upper: assert property (p_hclk_upper) else $error("unused hclk bits set");
  property p_special;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_SPECIAL |->
      frame_out.data[1311:655] == '0 && frame_out.data[639:0] == '0 && frame_out.addr.minor == 7'h00;
  endproperty
  a_special: assert property (p_special) else $error("special frame carries stray bits");
  property p_used_type;
    frame_valid |-> frame_out.addr.block_type <= cfg_frame_pkg::BT_BRAM_NONCFG && frame_out.addr.row < 5'h0a;
  endproperty
  a_used_type: assert property (p_used_type) else $error("frame for unused type or row");
  property p_top_then_bottom;
    s_top_end |=> st_r.frame_address_register.bottom && st_r.frame_address_register.row == 5'h00 && st_r.frame_address_register.major == 8'h00 && st_r.frame_address_register.minor == 7'h00;
  endproperty
  a_top_then_bottom: assert property (p_top_then_bottom) else $error("row scan order wrong");
  property p_bram_step;
    s_bram_col_end |=> st_r.frame_address_register.minor == 7'h00 && st_r.frame_address_register.major == $past(st_r.frame_address_register.major) + 8'h01;
  endproperty
  a_bram_step: assert property (p_bram_step) else $error("content column not 128 frames");

  // The address walk is checked field by field so that a fault names the field that went wrong.
  sequence s_minor_end;
    s_frame_done ##0 ({1'b0, st_r.frame_address_register.minor} + 8'h01 == frames_cur);
  endsequence
  sequence s_row_end;
    s_minor_end ##0 ({1'b0, st_r.frame_address_register.major} + 9'h001 == {1'b0, ncols_seq});
  endsequence

  // Word counting: only a taken word or an address load may move the count.
  property p_word_step;
    accept && !last_word |=> st_r.wcnt == $past(st_r.wcnt) + 6'h01;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word count did not step");
  property p_word_hold;
    !accept && !far_load |=> $stable(st_r.wcnt);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word count moved without a word");
  property p_frame_pulse;
    frame_valid |=> !frame_valid;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
  property p_load_drops;
    far_load |=> !frame_valid;
  endproperty
  a_load_drops: assert property (p_load_drops) else $error("frame ended across a load");

  // Address stepping after a finished frame.
  property p_minor_step;
    s_frame_done ##0 ({1'b0, st_r.frame_address_register.minor} + 8'h01 < frames_cur) |=>
      st_r.frame_address_register.minor == $past(st_r.frame_address_register.minor) + 7'h01 && $stable(st_r.frame_address_register.major);
  endproperty
  a_minor_step: assert property (p_minor_step) else $error("minor did not step");
  property p_major_step;
    s_minor_end ##0 ({1'b0, st_r.frame_address_register.major} + 9'h001 < {1'b0, ncols_seq}) |=>
      st_r.frame_address_register.minor == 7'h00 && st_r.frame_address_register.major == $past(st_r.frame_address_register.major) + 8'h01;
  endproperty
  a_major_step: assert property (p_major_step) else $error("major did not step");
  property p_row_step;
    s_row_end ##0 ({1'b0, st_r.frame_address_register.row} + 6'h01 < {2'h0, st_r.nrows}) |=>
      st_r.frame_address_register.major == 8'h00 && st_r.frame_address_register.row == $past(st_r.frame_address_register.row) + 5'h01 && $stable(st_r.frame_address_register.bottom);
  endproperty
  a_row_step: assert property (p_row_step) else $error("row did not step");
  property p_bad_frame;
    accept && last_word && !addr_ok |=> !frame_valid && st_r.bad_type && $stable(st_r.frame_address_register);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad address not refused");

  // Column kind is taken one cycle back, from the cycle of the last word.
  property p_minor_range;
    frame_valid |-> {1'b0, frame_out.addr.minor} < $past(frames_cur);
  endproperty
  a_minor_range: assert property (p_minor_range) else $error("minor past column");
  property p_content_major;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_BRAM_CONTENT |->
      frame_out.addr.major < $past(st_r.nbram);
  endproperty
  a_content_major: assert property (p_content_major) else $error("content major past ram columns");
  property p_role_ic;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_CONFIG && frame_out.addr.minor <= 7'h19 &&
      $past(column_kind) != cfg_frame_pkg::COL_CLOCK |-> frame_out.role == cfg_frame_pkg::ROLE_INTERCONNECT;
  endproperty
  a_role_ic: assert property (p_role_ic) else $error("interconnect role wrong");
  property p_role_if;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_CONFIG && frame_out.addr.minor[6:1] == 6'h0d &&
      $past(column_kind) != cfg_frame_pkg::COL_LOGIC && $past(column_kind) != cfg_frame_pkg::COL_CLOCK |->
      frame_out.role == cfg_frame_pkg::ROLE_INTERFACE;
  endproperty
  a_role_if: assert property (p_role_if) else $error("interface role wrong");
  property p_role_other;
    frame_valid && frame_out.addr.block_type != cfg_frame_pkg::BT_CONFIG |->
      frame_out.role == cfg_frame_pkg::ROLE_SPECIFIC;
  endproperty
  a_role_other: assert property (p_role_other) else $error("role of other type wrong");

  // The gates are levels: they move only on the pulse of a special frame.
  property p_gates_hold;
    !frame_valid |-> $stable({gts_gate, capture_restore_gate, hold_gwe_gate});
  endproperty
  a_gates_hold: assert property (p_gates_hold) else $error("gate moved without a frame");
  property p_gates_load;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_SPECIAL |->
      {capture_restore_gate, hold_gwe_gate} == frame_out.data[653:652];
  endproperty
  a_gates_load: assert property (p_gates_load) else $error("gates differ from frame");
  property p_gts_io;
    frame_valid && frame_out.addr.block_type == cfg_frame_pkg::BT_SPECIAL |->
      gts_gate == (frame_out.data[654] && $past(column_kind) == cfg_frame_pkg::COL_IO);
  endproperty
  a_gts_io: assert property (p_gts_io) else $error("tristate gate outside io column");
endmodule

// File: test/cfg_packet_src.sv
// Packet processor model: loads the frame address, then streams frame words to the sequencer.
// Assumes one caller of send at a time and the column kind lookup of the storage side.
`timescale 1ns/1ps
module cfg_packet_src (
  input wire logic pclk,
  input wire logic word_ready,
  output logic far_load,
  output logic [31:0] far_value,
  output logic word_valid,
  output logic [31:0] word_data,
  output logic [2:0] column_kind
);
  // Column kinds by major, three bits each; the last column stands in for the clock column.
  localparam logic [23:0] KT = {3'h4, 3'h2, 3'h0, 3'h1, 3'h2, 3'h0, 3'h2, 3'h3};
  logic [7:0] cur_major;
  function automatic logic [2:0] kd(input logic [7:0] m);
    return KT[3*m[2:0] +: 3];
  endfunction
  assign column_kind = kd(cur_major);
  // Idle levels at time zero.
  initial begin
    far_load = 1'b0;
    far_value = 32'h0;
    word_valid = 1'b0;
    word_data = 32'h0;
    cur_major = 8'h00;
  end
  // Offers n words; a released data line shows the inverse so stale values never match by luck.
  task automatic send(input logic [31:0] a, input logic [1311:0] d, input int n, input bit slow);
    @(posedge pclk);
    far_load <= 1'b1;
    far_value <= a;
    cur_major <= a[14:7];
    @(posedge pclk);
    far_load <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (slow && $urandom_range(1) == 1) begin
        word_valid <= 1'b0;
        word_data <= ~word_data;
        @(posedge pclk);
      end
      word_valid <= 1'b1;
      word_data <= d[1311-32*i -: 32];
      @(posedge pclk);
      while (word_ready !== 1'b1) @(posedge pclk);
    end
    word_valid <= 1'b0;
    word_data <= ~d[1311-32*(n-1) -: 32];
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the frame address sequencer.
// Assumes the packet source model drives the word stream and column kinds.
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cfg_frame_pkg::apb_req_type apb_in = '0;
  cfg_frame_pkg::apb_rsp_type apb_out;
  logic far_load, word_valid, word_ready, frame_valid, gts_gate, capture_restore_gate, hold_gwe_gate;
  logic [31:0] far_value, word_data, rd;
  logic [2:0] column_kind;
  logic err;
  cfg_frame_pkg::frame_out_type frame_out, cf;
  cfg_frame_pkg::frame_out_type exp_q [$];
  bit role_q [$];
  bit ck;
  int n_mismatch = 0;
  int tests_run = 0;
  // Frame counts per column kind, logic first.
  localparam logic [39:0] FC = {8'h04, 8'h36, 8'h1e, 8'h1c, 8'h24};
  always #10 pclk = ~pclk;
  config_frame_addressing uut (.pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
    .far_load(far_load), .far_value(far_value), .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .column_kind(column_kind), .frame_valid(frame_valid), .frame_out(frame_out),
    .gts_gate(gts_gate), .capture_restore_gate(capture_restore_gate), .hold_gwe_gate(hold_gwe_gate));
  cfg_packet_src src (.pclk(pclk), .word_ready(word_ready), .far_load(far_load), .far_value(far_value),
    .word_valid(word_valid), .word_data(word_data), .column_kind(column_kind));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [1311:0] seen, input logic [1311:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_in.psel <= 1'b1;
    apb_in.pwrite <= w;
    apb_in.paddr <= a;
    apb_in.pwdata <= wd;
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    do @(posedge pclk); while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask
  function automatic logic [31:0] f(input int bt, input int bo, input int row, input int mj, input int mi);
    return {8'h00, bt[2:0], bo[0], row[4:0], mj[7:0], mi[6:0]};
  endfunction
  function automatic logic [7:0] lim(input logic [31:0] a);
    if (a[23:21] == 3'h1) return 8'h80;
    if (a[23:21] != 3'h0) return 8'h01;
    return FC[8*src.kd(a[14:7]) +: 8];
  endfunction
  function automatic bit ok(input logic [31:0] a);
    return a[23:21] < 3'h4 && a[19:15] < 5'h0a && a[6:0] < lim(a) && a[14:7] < ((a[23:21] == 3'h1) ? 3 : 8);
  endfunction
  // Next address: minor, then major, then row; past the last row the half flips.
  function automatic logic [31:0] nx(input logic [31:0] a);
    if (a[6:0] + 1 < lim(a)) return a + 32'h1;
    a[6:0] = 7'h00;
    if (a[14:7] + 1 < ((a[23:21] == 3'h1) ? 3 : 8)) return a + 32'h80;
    a[14:7] = 8'h00;
    if (a[19:15] < 5'h09) return a + 32'h8000;
    a[19:15] = 5'h00;
    a[20] = ~a[20];
    return a;
  endfunction
  // Sends n words to address a and notes the frame that must come out, if any.
  task automatic frame(input logic [31:0] a, input int n);
    logic [1311:0] d;
    logic [2:0] k;
    cfg_frame_pkg::frame_out_type e;
    for (int i = 0; i < 41; i++) d[1311-32*i -: 32] = $urandom;
    k = src.kd(a[14:7]);
    e.addr = a;
    e.data = d;
    e.data[671:656] = 16'h0000;
    if (a[23:21] == 3'h2) begin
      e.data = '0;
      e.data[654:640] = d[654:640];
    end
    e.role = (a[6:0] <= 25 && k != 4) ? 2'h0 : (a[6:0] <= 27 && k != 0 && k != 4) ? 2'h1 : 2'h2;
    if (n == 41 && ok(a)) begin
      exp_q.push_back(e);
      role_q.push_back(a[23:21] == 3'h0);
    end
    src.send(a, d, n, $urandom_range(1));
    repeat (3) @(posedge pclk);
    if (n < 41) return;
    apb(1'b0, 12'h004, 32'h0);
    check("far", rd, ok(a) ? nx(a) : a);
    apb(1'b0, 12'h008, 32'h0);
    check("bad type", rd[16], !ok(a));
    if (!ok(a)) apb(1'b1, 12'h008, 32'h00010000);
    if (ok(a) && a[23:21] == 3'h2) begin
      check("gates", {capture_restore_gate, hold_gwe_gate}, d[653:652]);
      check("gts", gts_gate, (k == 3) ? d[654] : 1'b0);
    end
    $display("Test done: frame %h", a);
  endtask
  // Each frame pulse retires the oldest noted frame.
  always @(posedge pclk) begin
    if (frame_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected frame", 1'b1, 1'b0);
      end else begin
        cf = exp_q.pop_front();
        ck = role_q.pop_front();
        check("frame addr", frame_out.addr, cf.addr);
        check("frame data", frame_out.data, cf.data);
        if (ck) check("frame role", frame_out.role, cf.role);
      end
    end
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #500000;
    n_mismatch++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4cee));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check("config reset", rd, 32'h010a0308);
    apb(1'b0, 12'h00c, 32'h0);
    check("gates reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h000, 32'h000a0308);
    @(posedge pclk);
    check("ready off", word_ready, 1'b0);
    apb(1'b1, 12'h000, 32'h010a0308);
    apb(1'b1, 12'h004, 32'hffffffff);
    apb(1'b0, 12'h004, 32'h0);
    check("far read only", rd, 32'h0);
    $display("Test done: registers");
    frame(f(0, 0, 0, 0, 0), 41);
    frame(f(0, 0, 0, 4, 25), 41);
    frame(f(0, 0, 0, 4, 26), 41);
    frame(f(0, 0, 0, 2, 26), 41);
    frame(f(0, 0, 0, 2, 35), 41);
    frame(f(0, 0, 0, 1, 29), 41);
    frame(f(0, 0, 0, 7, 0), 41);
    frame(f(0, 0, 0, 7, 3), 41);
    frame(f(0, 0, 9, 7, 3), 41);
    frame(f(0, 1, 0, 0, 53), 41);
    frame(f(0, 0, 0, 2, 36), 41);
    frame(f(0, 0, 10, 0, 0), 41);
    frame(f(1, 0, 0, 2, 127), 41);
    frame(f(1, 0, 0, 0, 127), 41);
    frame(f(1, 0, 0, 3, 0), 41);
    frame(f(2, 0, 0, 0, 0), 41);
    frame(f(2, 0, 0, 5, 0), 41);
    frame(f(2, 0, 0, 0, 1), 41);
    frame(f(3, 0, 0, 1, 0), 41);
    for (int i = 4; i < 8; i++) frame(f(i, 0, 0, 0, 0), 41);
    frame(f(0, 0, 3, 4, 5), 10);
    frame(f(0, 1, 5, 6, 7), 41);
    check("pending frames", exp_q.size(), 0);
    end_sim();
  end
endmodule
